// file: sar_pkg.sv
package sar_pkg;
   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int RES_BITS = 18;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_NS = 58;
   localparam int CONV_CYCLES =
      (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [17:0] TEST_PATTERN = 18'h2A5A5;
   localparam logic [17:0] RESET_SAMPLE = 18'h00000;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] RESULT_OFS = 12'h008;
   localparam logic [11:0] SAMPLE_OFS = 12'h00C;
   localparam int CTRL_SLEEP_N = 0;
   localparam int CTRL_PATTERN = 1;
   localparam int CTRL_DUAL    = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;
   localparam int ST_BUSY  = 0;
   localparam int ST_VALID = 1;
   localparam int ST_BITS  = 8;
   typedef enum logic [1:0] {
      ST_ACQ  = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } conv_state_t;
endpackage

// file: sar_core.sv
`timescale 1ns/1ps
// one comparator decision per clock, msb first
module sar_core #(
   parameter int WIDTH = 18
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // control
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] held,
   // result
   output logic                  busy,
   output logic                  done,
   output logic [WIDTH-1:0]      result
);
   logic [WIDTH-1:0] trial_q, trial_d, acc_q, acc_d;
   logic [WIDTH-1:0] held_q, held_d;
   logic             done_q, done_d;
   logic [WIDTH-1:0] cand;

   // ----------------------------------------------------------------
   // binary search against weighted fractions
   // ----------------------------------------------------------------
   // sample is two's complement; offset it so compare is unsigned
   always_comb begin
      trial_d = trial_q;
      acc_d   = acc_q;
      held_d  = held_q;
      done_d  = 1'b0;
      cand    = acc_q | trial_q;
      if (start) begin
         held_d  = held ^ {1'b1, {(WIDTH-1){1'b0}}};
         acc_d   = '0;
         trial_d = {1'b1, {(WIDTH-1){1'b0}}};
      end else if (trial_q != '0) begin
         if (cand <= held_q)
            acc_d = cand;
         trial_d = trial_q >> 1;
         done_d  = (trial_q == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trial_q <= '0;
         acc_q   <= '0;
         held_q  <= '0;
         done_q  <= 1'b0;
      end else begin
         trial_q <= trial_d;
         acc_q   <= acc_d;
         held_q  <= held_d;
         done_q  <= done_d;
      end
   end

   assign busy   = (trial_q != '0);
   assign done   = done_q;
   // back to two's complement
   assign result = acc_q ^ {1'b1, {(WIDTH-1){1'b0}}};
endmodule

// file: sar_adc_serial_readout.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module sar_adc_serial_readout #(
   parameter int WIDTH = 18
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // converter pins
   input  wire logic             convert_strobe,
   input  wire logic             shift_clock_in,
   input  wire logic [WIDTH-1:0] analog_sample,
   output logic                  lane_a_out,
   output logic                  lane_b_out,
   output logic                  lane_b_oe_n,
   output logic                  lanes_oe_n,
   output logic                  echo_clock_out,
   output logic                  tracking
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] cnv_s1_q, cnv_s2_q, cnv_s3_q;
   logic [1:0] cnv_d1, cnv_d2, cnv_d3;
   // sample bus is held steady around the strobe by the front end
   logic [WIDTH-1:0] smp_s1_q, smp_s2_q, smp_d1, smp_d2;

   // slots: 0 strobe, 1 shift clock; third stage only for edges
   always_comb begin
      cnv_d1 = {shift_clock_in, convert_strobe};
      cnv_d2 = cnv_s1_q;
      cnv_d3 = cnv_s2_q;
      smp_d1 = analog_sample;
      smp_d2 = smp_s1_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnv_s1_q <= 2'h0;
         cnv_s2_q <= 2'h0;
         cnv_s3_q <= 2'h0;
         smp_s1_q <= '0;
         smp_s2_q <= '0;
      end else begin
         cnv_s1_q <= cnv_d1;
         cnv_s2_q <= cnv_d2;
         cnv_s3_q <= cnv_d3;
         smp_s1_q <= smp_d1;
         smp_s2_q <= smp_d2;
      end
   end

   logic cnv_rise, sck_rise, sck_fall;
   assign cnv_rise = cnv_s2_q[0] & ~cnv_s3_q[0];
   assign sck_rise = cnv_s2_q[1] & ~cnv_s3_q[1];
   assign sck_fall = ~cnv_s2_q[1] & cnv_s3_q[1];

   // ----------------------------------------------------------------
   // apb registers
   // ----------------------------------------------------------------
   logic [2:0]  ctrl_q, ctrl_d;
   logic [31:0] rdata;
   logic        wr_en;
   logic        active;

   assign wr_en  = psel & penable & pwrite;
   // single-cycle access phase, no wait states
   assign pready = 1'b1;
   assign active = ctrl_q[sar_pkg::CTRL_SLEEP_N];

   function automatic logic known_ofs(input logic [11:0] a);
      return (a == sar_pkg::CTRL_OFS) || (a == sar_pkg::STATUS_OFS) ||
             (a == sar_pkg::RESULT_OFS) || (a == sar_pkg::SAMPLE_OFS);
   endfunction

   assign pslverr = psel & penable & ~known_ofs(paddr);

   // control writes
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_en && paddr == sar_pkg::CTRL_OFS)
         ctrl_d = pwdata[2:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_q <= sar_pkg::CTRL_RESET;
      else
         ctrl_q <= ctrl_d;
   end

   // ----------------------------------------------------------------
   // acquisition and conversion
   // ----------------------------------------------------------------
   sar_pkg::conv_state_t st_q, st_d;
   logic [WIDTH-1:0] word_q, word_d;
   logic             valid_q, valid_d;
   logic             core_busy, core_done;
   logic [WIDTH-1:0] core_result;
   logic             start;

   // strobe ignored while asleep
   assign start = cnv_rise & active;

   sar_core #(
      .WIDTH (WIDTH)
   ) u_core (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (start),
      .held    (smp_s2_q),
      .busy    (core_busy),
      .done    (core_done),
      .result  (core_result)
   );

   // track until strobe, convert, then back to tracking
   // conversion runs about twenty clocks, longer than the pin figure;
   // a host that clocks out early must poll the valid bit instead
   always_comb begin
      st_d    = st_q;
      word_d  = word_q;
      valid_d = valid_q;
      case (st_q)
         sar_pkg::ST_ACQ: begin
            if (start) begin
               st_d    = sar_pkg::ST_CONV;
               valid_d = 1'b0;
            end
         end
         sar_pkg::ST_CONV: begin
            if (core_done) begin
               // same strobe's sample, no pipeline
               word_d  = core_result;
               valid_d = 1'b1;
               st_d    = sar_pkg::ST_DONE;
            end
         end
         sar_pkg::ST_DONE: begin
            // a strobe in the last cycle must not be lost
            if (start) begin
               st_d    = sar_pkg::ST_CONV;
               valid_d = 1'b0;
            end else begin
               st_d = sar_pkg::ST_ACQ;
            end
         end
         default: st_d = sar_pkg::ST_ACQ;
      endcase
      if (!active) begin
         st_d    = sar_pkg::ST_ACQ;
         valid_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= sar_pkg::ST_ACQ;
         word_q  <= sar_pkg::RESET_SAMPLE;
         valid_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         word_q  <= word_d;
         valid_q <= valid_d;
      end
   end

   assign tracking = active & (st_q == sar_pkg::ST_ACQ);

   // ----------------------------------------------------------------
   // serial shifter
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] sh_q, sh_d;
   logic [4:0]       bits_q, bits_d;
   logic             la_q, la_d, lb_q, lb_d, dco_q, dco_d;
   logic             dual;
   logic [WIDTH-1:0] src;

   assign dual = ctrl_q[sar_pkg::CTRL_DUAL];
   // pattern replaces result at load time
   // fixed word with alternating bits shows swapped or stuck lanes
   assign src  = ctrl_q[sar_pkg::CTRL_PATTERN] ? sar_pkg::TEST_PATTERN
                                               : core_result;

   // load at end of conversion, bits step on shift clock rise
   // the rise after the last bit drives the lanes low; later rises leave the lanes as they are
   always_comb begin
      sh_d   = sh_q;
      bits_d = bits_q;
      la_d   = la_q;
      lb_d   = lb_q;
      dco_d  = cnv_s2_q[1] & active;
      if (st_q == sar_pkg::ST_CONV && core_done) begin
         sh_d   = src;
         bits_d = 5'(WIDTH);
         la_d   = src[WIDTH-1]; // msb first
         lb_d   = dual ? src[WIDTH-2] : 1'b0;
      end else if (sck_rise && bits_q != 5'h00) begin
         if (dual) begin
            sh_d   = {sh_q[WIDTH-3:0], 2'b00};
            bits_d = (bits_q > 5'h02) ? bits_q - 5'h02 : 5'h00;
         end else begin
            sh_d   = {sh_q[WIDTH-2:0], 1'b0};
            bits_d = bits_q - 5'h01;
         end
         la_d = sh_d[WIDTH-1];
         lb_d = dual ? sh_d[WIDTH-2] : 1'b0;
      end
      if (!active) begin
         bits_d = 5'h00;
         la_d   = 1'b0;
         lb_d   = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q   <= '0;
         bits_q <= 5'h00;
         la_q   <= 1'b0;
         lb_q   <= 1'b0;
         dco_q  <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         bits_q <= bits_d;
         la_q   <= la_d;
         lb_q   <= lb_d;
         dco_q  <= dco_d;
      end
   end

   assign lane_a_out     = la_q;
   assign lane_b_out     = lb_q;
   assign echo_clock_out = dco_q;
   // enables active low; asleep shuts all drivers
   assign lanes_oe_n     = ~active;
   assign lane_b_oe_n    = ~(active & dual);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 32'h00000000;
      case (paddr)
         sar_pkg::CTRL_OFS:   rdata[2:0] = ctrl_q;
         sar_pkg::STATUS_OFS: begin
            rdata[sar_pkg::ST_BUSY]  = core_busy;
            rdata[sar_pkg::ST_VALID] = valid_q;
            rdata[sar_pkg::ST_BITS +: 5] = bits_q;
         end
         sar_pkg::RESULT_OFS: rdata[WIDTH-1:0] = word_q;
         sar_pkg::SAMPLE_OFS: rdata[WIDTH-1:0] = smp_s2_q;
         default: rdata = 32'h00000000;
      endcase
   end

   // data output registered in the setup phase of a read
   logic [31:0] prdata_q, prdata_d;
   always_comb begin
      prdata_d = prdata_q;
      if (psel && !penable && !pwrite)
         prdata_d = rdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else
         prdata_q <= prdata_d;
   end

   assign prdata = prdata_q;
endmodule

// file: sar_readout_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module sar_readout_chk #(
   parameter int WIDTH = 18
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins
   input wire logic        convert_strobe,
   input wire logic        shift_clock_in,
   input wire logic        lane_b_oe_n,
   input wire logic        lanes_oe_n,
   input wire logic        echo_clock_out,
   input wire logic        tracking
);
   logic acc;
   logic mapped;
   // access phase and decode of the four words
   assign acc = psel && penable;
   assign mapped = paddr inside {sar_pkg::CTRL_OFS, sar_pkg::STATUS_OFS,
      sar_pkg::RESULT_OFS, sar_pkg::SAMPLE_OFS};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_no_wait_a: assert property (acc |-> pready)
      else $error("apb access not answered at once");
   bad_addr_err_a: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   good_addr_ok_a: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   bad_read_zero_a: assert property (acc && !pwrite && !mapped
      |-> prdata == 32'h0) else $error("unmapped read not zero");
   // one cycle of grace: the echo register lags the sleep bit
   sleep_echo_off_a: assert property (
      lanes_oe_n && $past(lanes_oe_n) |-> !echo_clock_out)
      else $error("echo clock runs while asleep");
   sleep_no_track_a: assert property (
      lanes_oe_n && $past(lanes_oe_n) |-> !tracking)
      else $error("tracking while asleep");
   lane_b_awake_a: assert property (!lane_b_oe_n |-> !lanes_oe_n)
      else $error("lane b driver on while asleep");
   echo_copy_a: assert property ($rose(echo_clock_out) |->
      $past(shift_clock_in, 2) && $past(shift_clock_in, 3))
      else $error("echo rose without shift clock");
   strobe_holds_a: assert property (
      $rose(convert_strobe) && !lanes_oe_n |-> ##[1:8] !tracking)
      else $error("strobe did not end acquisition");
endmodule
bind sar_adc_serial_readout sar_readout_chk #(.WIDTH(WIDTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .convert_strobe(convert_strobe),
   .shift_clock_in(shift_clock_in), .lane_b_oe_n(lane_b_oe_n),
   .lanes_oe_n(lanes_oe_n), .echo_clock_out(echo_clock_out),
   .tracking(tracking));

// file: sar_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller: strobe, framed clock, capture
// ----------------------------------------
module sar_ctrl_model (
   // bench request
   input  wire logic   go,
   input  wire logic   dual,
   // device pins
   input  wire logic   lane_a_out,
   input  wire logic   lane_b_out,
   output logic        convert_strobe,
   output logic        shift_clock_in,
   // capture
   output logic [17:0] word,
   output logic        busy
);
   int i;
   // clock stands low between frames
   initial begin
      convert_strobe = 1'b0;
      shift_clock_in = 1'b0;
      word = 18'h00000;
      busy = 1'b0;
   end
   // one frame per go, 64 ns shift period
   always @(posedge go) begin
      // half a ns off the pclk grid: pins never move on a sampling edge
      #0.5;
      busy = 1'b1;
      convert_strobe = 1'b1;
      #20 convert_strobe = 1'b0;
      #180; // slow conversion, first rise far past 65 ns
      for (i = 0; i < (dual ? 9 : 18); i++) begin
         // lanes still show the bit of the last rise
         word = dual ? {word[15:0], lane_a_out, lane_b_out}
                     : {word[16:0], lane_a_out};
         shift_clock_in = 1'b1;
         #32 shift_clock_in = 1'b0;
         #32;
      end
      busy = 1'b0; // next strobe only after last fall
   end
endmodule

// file: sar_adc_serial_readout_tb.sv
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
   typedef struct packed {
      logic [17:0] smp;
      logic        pat;
      logic        dual;
      logic [17:0] exp;
   } row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        convert_strobe, shift_clock_in, lane_a_out, lane_b_out;
   logic        lane_b_oe_n, lanes_oe_n, echo_clock_out, tracking;
   logic [17:0] analog_sample, word;
   logic        go, dual, mbusy, err;
   int          n_mismatch, n_compared;
   row_t        rows [5] = '{
      '{18'h20000, 1'b0, 1'b0, 18'h20000},
      '{18'h1FFFF, 1'b0, 1'b1, 18'h1FFFF},
      '{18'h0F0F1, 1'b1, 1'b0, sar_pkg::TEST_PATTERN},
      '{18'h3FFFF, 1'b1, 1'b1, sar_pkg::TEST_PATTERN},
      '{18'h3FFFF, 1'b0, 1'b0, 18'h3FFFF}};
   sar_adc_serial_readout u_sar_adc_serial_readout (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convert_strobe(convert_strobe),
      .shift_clock_in(shift_clock_in), .analog_sample(analog_sample),
      .lane_a_out(lane_a_out), .lane_b_out(lane_b_out),
      .lane_b_oe_n(lane_b_oe_n), .lanes_oe_n(lanes_oe_n),
      .echo_clock_out(echo_clock_out), .tracking(tracking));
   sar_ctrl_model u_sar_ctrl_model (
      .go(go), .dual(dual), .lane_a_out(lane_a_out),
      .lane_b_out(lane_b_out), .convert_strobe(convert_strobe),
      .shift_clock_in(shift_clock_in), .word(word), .busy(mbusy));
   // 200 MHz
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task check(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer; request held until pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task frame(input logic d);
      @(posedge pclk);
      go <= 1'b1;
      dual <= d;
      repeat (20) @(posedge pclk);
      analog_sample <= ~analog_sample; // held sample must not move
      go <= 1'b0;
      wait (mbusy === 1'b0);
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, go, dual} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      analog_sample = 18'h00000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sar_pkg::CTRL_OFS, 32'h0);
      check("ctrl", {29'h0, sar_pkg::CTRL_RESET}, rd);
      check("track", 32'h1, {31'h0, tracking});
      apb(1'b0, 12'h010, 32'h0);
      check("err", 32'h1, {31'h0, err});
      check("rdata", 32'h0, rd);
      foreach (rows[k]) begin
         apb(1'b1, sar_pkg::CTRL_OFS, {29'h0, rows[k].dual, rows[k].pat, 1'b1});
         analog_sample <= rows[k].smp;
         frame(rows[k].dual);
         check("word", {14'h0, rows[k].exp}, {14'h0, word});
         check("b_oe", {31'h0, ~rows[k].dual}, {31'h0, lane_b_oe_n});
      end
      check("offbin", 32'h0001FFFF, {14'h0, word ^ 18'h20000});
      // registers after the last row: stored word, status, raw sample
      apb(1'b0, sar_pkg::RESULT_OFS, 32'h0);
      check("result", 32'h0003FFFF, rd);
      analog_sample <= 18'h15A5A;
      apb(1'b0, sar_pkg::STATUS_OFS, 32'h0);
      check("status", 32'h00000002, rd);
      apb(1'b0, sar_pkg::SAMPLE_OFS, 32'h0);
      check("sample", 32'h00015A5A, rd);
      // asleep: drivers off, strobe ignored
      apb(1'b1, sar_pkg::CTRL_OFS, 32'h0);
      frame(1'b0);
      check("oe", 32'h1, {31'h0, lanes_oe_n});
      check("b_oe", 32'h1, {31'h0, lane_b_oe_n});
      check("track", 32'h0, {31'h0, tracking});
      apb(1'b1, sar_pkg::CTRL_OFS, 32'h1);
      // the write lands on the edge that ended the task
      @(posedge pclk);
      check("oe", 32'h0, {31'h0, lanes_oe_n});
      give_verdict;
   end
   // whole run is about 7 us; some sixteen times that means a hang
   initial begin
      #120000;
      n_mismatch++;
      give_verdict;
   end
endmodule
